// ### core/ast_serial_top.sv
// Operation
// - start, 8 or 9 data, one stop
// - data bits travel lsb first
// - independent paths, shared format and rate
// - baud clock x16 high speed, x64 low
// - no parity, ninth bit passed through
// - transfers halt during sleep
// - async when sync clear and port enabled
// - shifter loads only after previous stop bit
// - holding-to-shifter move takes one cycle
// - empty flag sets only while transmit is enabled
// - a holding write or transmit disable clears empty flag
// - shifter-empty bit reads one when idle
// - shifter itself not visible to software
// - transmit enable sets the empty flag
// - empty flag clears second cycle after write
// - receiver oversamples at x16 bit rate
// - ready flag on complete character
// - clearing continuous receive clears errors
// - nine-bit receive stores ninth bit
// - address detect passes only address characters
// - interrupt needs both enables set
// - address detect needs ninth bit one
// - rate is clock over 16/64 times divisor+1
// - pin level from three-sample majority
// - divisor write restarts baud timer
//
// The APB slave port and the address map were chosen for this implementation.
module ast_serial_top import ast_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic sleep_mode,
	input wire logic receive_pin,
	output logic tx_pin,
	output logic tx_pin_oe,
	output logic irq_req
);
	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	logic pready_r, pslverr_r, tx_line_r, tx_oe_r, irq_r;
	logic [31:0] prdata_r;
	logic [7:0] baud_divisor_reg, tx_holding_reg, rx_buffer_reg;
	logic [7:0] flag_rest_r, peripheral_irq_enable_reg, peripheral_priority_reg;
	logic clock_source_select, tx_ninth_enable, tx_enable, sync_sel;
	logic high_speed_select, tx_ninth_bit;
	logic port_enable, rx_ninth_enable, single_rx_enable, continuous_rx_enable;
	logic addr_detect_enable, framing_error, overrun_error, rx_ninth_bit;
	logic global_irq_enable, hold_full_r, tx_buffer_empty_flag, rx_ready_flag;
	ast_line_state_type tx_st, rx_st;
	logic [3:0] tx_sub, tx_cnt, rx_sub, rx_cnt;
	logic [8:0] tx_shifter, rx_shifter;
	logic tx_len9, rx_seen_high;
	logic os_tick, vote;

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire acc = psel && penable && pready_r;
	wire wr_en = acc && pwrite;
	wire rd_en = acc && !pwrite;
	wire sel_baud = paddr == OFS_BAUD;
	wire sel_txsc = paddr == OFS_TXSC;
	wire sel_rxsc = paddr == OFS_RXSC;
	wire sel_txh = paddr == OFS_TXHOLD;
	wire sel_rxb = paddr == OFS_RXBUF;
	wire sel_flag = paddr == OFS_FLAG;
	wire sel_ien = paddr == OFS_IRQEN;
	wire sel_prio = paddr == OFS_PRIO;
	wire sel_glob = paddr == OFS_GLOBAL;
	wire mapped = sel_baud | sel_txsc | sel_rxsc | sel_txh | sel_rxb | sel_flag
		| sel_ien | sel_prio | sel_glob;
	wire wr_hold = wr_en && sel_txh;
	wire rd_rxbuf = rd_en && sel_rxb;
	wire div_wr = wr_en && sel_baud;
	wire [7:0] w8 = pwdata[7:0];

	// ---------------------------------------------------------------
	// status views
	// ---------------------------------------------------------------
	wire shifter_empty = tx_st == ST_IDLE;
	wire port_on = port_enable && !sync_sel;
	wire [7:0] txsc_rd = {clock_source_select, tx_ninth_enable, tx_enable, sync_sel,
		1'b0, high_speed_select, shifter_empty, tx_ninth_bit};
	wire [7:0] rxsc_rd = {port_enable, rx_ninth_enable, single_rx_enable,
		continuous_rx_enable, addr_detect_enable, framing_error, overrun_error, rx_ninth_bit};
	wire [7:0] flag_rd = {flag_rest_r[7:6], rx_ready_flag, tx_buffer_empty_flag,
		flag_rest_r[3:0]};
	// the shifter has no address; only the holding register is seen
	wire [7:0] rd8 = sel_baud ? baud_divisor_reg : sel_txsc ? txsc_rd
		: sel_rxsc ? rxsc_rd : sel_txh ? tx_holding_reg : sel_rxb ? rx_buffer_reg
		: sel_flag ? flag_rd : sel_ien ? peripheral_irq_enable_reg
		: sel_prio ? peripheral_priority_reg : sel_glob ? {global_irq_enable, 7'h00}
		: 8'h00;

	// one wait state: data and error are captured on the same edge that raises pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata_r <= '0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= psel && penable && !pready_r;
			if (psel && penable && !pready_r) begin
				prdata_r <= {24'h000000, rd8};
				pslverr_r <= !mapped;
			end
		end
	end

	// ---------------------------------------------------------------
	// software-written control
	// ---------------------------------------------------------------
	// the ready and empty flags in the flag register are hardware owned; writes skip them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_divisor_reg <= RST_BAUD;
			tx_holding_reg <= RST_DATA;
			{clock_source_select, tx_ninth_enable, tx_enable, sync_sel} <= RST_TXSC[7:4];
			{high_speed_select, tx_ninth_bit} <= {RST_TXSC[2], RST_TXSC[0]};
			{port_enable, rx_ninth_enable, single_rx_enable} <= RST_RXSC[7:5];
			{continuous_rx_enable, addr_detect_enable} <= RST_RXSC[4:3];
			flag_rest_r <= RST_FLAG;
			peripheral_irq_enable_reg <= RST_IRQEN;
			peripheral_priority_reg <= RST_PRIO;
			global_irq_enable <= 1'b0;
		end else if (wr_en) begin
			if (sel_baud) baud_divisor_reg <= w8;
			if (sel_txh) tx_holding_reg <= w8;
			if (sel_txsc) begin
				{clock_source_select, tx_ninth_enable, tx_enable, sync_sel} <= w8[7:4];
				high_speed_select <= w8[TXSC_HIGH_SPEED];
				tx_ninth_bit <= w8[TXSC_NINTH_BIT];
			end
			if (sel_rxsc) begin
				{port_enable, rx_ninth_enable, single_rx_enable} <= w8[7:5];
				continuous_rx_enable <= w8[RXSC_CONT_EN];
				addr_detect_enable <= w8[RXSC_ADDR_DET];
			end
			if (sel_flag) flag_rest_r <= w8;
			if (sel_ien) peripheral_irq_enable_reg <= w8;
			if (sel_prio) peripheral_priority_reg <= w8;
			if (sel_glob) global_irq_enable <= w8[GLOBAL_IRQ_EN];
		end
	end

	// ---------------------------------------------------------------
	// shared baud generator and receive filter
	// ---------------------------------------------------------------
	wire run = port_on && !sleep_mode;
	ast_baud_gen #(.DIV_W(8)) u_baud (
		.pclk(pclk),
		.presetn(presetn),
		.run(run),
		.divisor(baud_divisor_reg),
		.div_wr(div_wr),
		.high_speed(high_speed_select),
		.baud_tick_r(),
		.os_tick_r(os_tick)
	);
	ast_rx_sampler u_samp (
		.pclk(pclk),
		.presetn(presetn),
		.os_tick(os_tick),
		.pin(receive_pin),
		.vote_r(vote)
	);

	// ---------------------------------------------------------------
	// transmitter
	// ---------------------------------------------------------------
	wire tx_act = run && tx_enable;
	wire tx_load = tx_act && shifter_empty && hold_full_r;
	wire tx_bit_end = os_tick && tx_sub == OS_LAST;
	wire [3:0] tx_last = tx_len9 ? LAST_BIT_9 : LAST_BIT_8;

	// bit time is sixteen x16 ticks; the load itself takes one clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_st <= ST_IDLE;
			tx_sub <= '0;
			tx_cnt <= '0;
			tx_shifter <= '0;
			tx_len9 <= 1'b0;
			tx_line_r <= 1'b1;
		end else if (!tx_act) begin
			if (!port_on || !tx_enable) begin
				tx_st <= ST_IDLE;
				tx_line_r <= 1'b1;
			end
		end else begin
			if (os_tick) tx_sub <= tx_sub + 4'h1;
			case (tx_st)
				ST_IDLE: if (tx_load) begin
					tx_shifter <= {tx_ninth_enable & tx_ninth_bit, tx_holding_reg};
					tx_len9 <= tx_ninth_enable;
					tx_sub <= '0;
					tx_line_r <= 1'b0;
					tx_st <= ST_START;
				end
				ST_START: if (tx_bit_end) begin
					tx_line_r <= tx_shifter[0];
					tx_cnt <= '0;
					tx_st <= ST_DATA;
				end
				ST_DATA: if (tx_bit_end) begin
					if (tx_cnt == tx_last) begin
						tx_line_r <= 1'b1;
						tx_st <= ST_STOP;
					end else begin
						tx_line_r <= tx_shifter[1];
						tx_shifter <= {1'b0, tx_shifter[8:1]};
						tx_cnt <= tx_cnt + 4'h1;
					end
				end
				ST_STOP: if (tx_bit_end) tx_st <= ST_IDLE;
				default: tx_st <= ST_IDLE;
			endcase
		end
	end

	// a holding write beats a same-cycle load so no character is lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_full_r <= 1'b0;
			tx_buffer_empty_flag <= 1'b0;
		end else begin
			if (wr_hold) begin
				hold_full_r <= 1'b1;
			end else if (tx_load) begin
				hold_full_r <= 1'b0;
			end
			// one clock of lag keeps the old flag visible after a write
			tx_buffer_empty_flag <= tx_enable && !hold_full_r;
		end
	end

	// ---------------------------------------------------------------
	// receiver
	// ---------------------------------------------------------------
	wire rx_act = run && continuous_rx_enable && !overrun_error;
	wire rx_mid = os_tick && rx_sub == RX_MID;
	wire rx_bit_end = os_tick && rx_sub == OS_LAST;
	wire [3:0] rx_last = rx_ninth_enable ? LAST_BIT_9 : LAST_BIT_8;
	wire rx_done = rx_act && rx_st == ST_STOP && rx_mid;
	wire [7:0] rx_data = rx_ninth_enable ? rx_shifter[7:0] : rx_shifter[8:1];
	wire rx_b8 = rx_ninth_enable && rx_shifter[8];
	wire rx_take = !(addr_detect_enable && rx_ninth_enable && !rx_shifter[8]);
	wire rx_full = rx_ready_flag && !rd_rxbuf;

	// start search waits for the line to be seen high first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_st <= ST_IDLE;
			rx_sub <= '0;
			rx_cnt <= '0;
			rx_shifter <= '0;
			rx_seen_high <= 1'b0;
		end else if (!rx_act) begin
			if (!sleep_mode) begin
				rx_st <= ST_IDLE;
				rx_seen_high <= 1'b0;
			end
		end else begin
			if (os_tick) rx_sub <= rx_sub + 4'h1;
			case (rx_st)
				ST_IDLE: if (os_tick) begin
					rx_seen_high <= vote;
					if (rx_seen_high && !vote) begin
						rx_sub <= 4'h1;
						rx_st <= ST_START;
					end
				end
				ST_START: begin
					if (rx_mid && vote) rx_st <= ST_IDLE;
					if (rx_bit_end) begin
						rx_cnt <= '0;
						rx_st <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (rx_mid) rx_shifter <= {vote, rx_shifter[8:1]};
					if (rx_bit_end) begin
						rx_cnt <= rx_cnt + 4'h1;
						if (rx_cnt == rx_last) rx_st <= ST_STOP;
					end
				end
				ST_STOP: if (rx_mid) begin
					rx_seen_high <= vote;
					rx_st <= ST_IDLE;
				end
				default: rx_st <= ST_IDLE;
			endcase
		end
	end

	// delivery wins over a same-cycle buffer read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buffer_reg <= RST_DATA;
			rx_ninth_bit <= 1'b0;
			rx_ready_flag <= 1'b0;
			framing_error <= 1'b0;
			overrun_error <= 1'b0;
		end else begin
			if (rx_done && rx_take && !rx_full) begin
				rx_buffer_reg <= rx_data;
				rx_ninth_bit <= rx_b8;
				framing_error <= !vote;
				rx_ready_flag <= 1'b1;
			end else if (rd_rxbuf) begin
				rx_ready_flag <= 1'b0;
			end
			if (rx_done && rx_take && rx_full) overrun_error <= 1'b1;
			if (!continuous_rx_enable) begin
				overrun_error <= 1'b0;
				framing_error <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	wire rx_irq = rx_ready_flag && peripheral_irq_enable_reg[FLAG_RX_READY];
	wire tx_irq = tx_buffer_empty_flag && peripheral_irq_enable_reg[FLAG_TX_EMPTY];

	// line stays high whenever the port is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_oe_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			tx_oe_r <= port_on;
			irq_r <= global_irq_enable && (rx_irq || tx_irq);
		end
	end
	assign pready = pready_r;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign tx_pin = tx_line_r;
	assign tx_pin_oe = tx_oe_r;
	assign irq_req = irq_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	empty_flag_lag_a: assert property (
		wr_hold |=> ##1 !tx_buffer_empty_flag)
		else $error("empty flag not clear two cycles after write");
	load_one_cycle_a: assert property (
		tx_load && !wr_hold && tx_enable |=> !hold_full_r ##1 tx_buffer_empty_flag)
		else $error("holding not emptied after load");
	// a waiting character must not cut the running stop bit short
	load_after_stop_a: assert property (
		(tx_load |=> tx_st == ST_START)
		and (tx_st == ST_STOP && tx_act && !tx_bit_end |=> tx_st == ST_STOP))
		else $error("shifter loaded mid character");
	line_levels_a: assert property (
		(tx_st == ST_START |-> !tx_line_r) and (tx_st == ST_STOP |-> tx_line_r))
		else $error("start or stop level wrong");
	sleep_halt_a: assert property (
		sleep_mode |=> $stable(tx_st) && $stable(rx_st) && $stable(tx_line_r))
		else $error("serial state moved in sleep");
	addr_filter_a: assert property (
		rx_done && addr_detect_enable && rx_ninth_enable && !rx_shifter[8]
		|=> $stable(rx_buffer_reg) && !$rose(rx_ready_flag))
		else $error("data character passed address filter");
	overrun_set_a: assert property (
		rx_done && rx_take && rx_full && continuous_rx_enable |=> overrun_error)
		else $error("overrun not flagged");
	err_clear_a: assert property (
		!continuous_rx_enable |=> !overrun_error && !framing_error)
		else $error("errors survive receive disable");
	irq_gate_a: assert property (
		irq_r |-> $past(global_irq_enable) && $past(rx_irq || tx_irq))
		else $error("interrupt without both enables");
	tx_load_c: cover property (tx_load ##1 wr_hold);
	rx_deliver_c: cover property (rx_done && rx_take && !rx_full);
	rx_overrun_c: cover property (rx_done && rx_full);
	addr_drop_c: cover property (rx_done && !rx_take);
endmodule

// ### core/ast_pkg.sv
package ast_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses on the register bus)
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_BAUD = 8'h00;
	localparam logic [7:0] OFS_TXSC = 8'h04;
	localparam logic [7:0] OFS_RXSC = 8'h08;
	localparam logic [7:0] OFS_TXHOLD = 8'h0c;
	localparam logic [7:0] OFS_RXBUF = 8'h10;
	localparam logic [7:0] OFS_FLAG = 8'h14;
	localparam logic [7:0] OFS_IRQEN = 8'h18;
	localparam logic [7:0] OFS_PRIO = 8'h1c;
	localparam logic [7:0] OFS_GLOBAL = 8'h20;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int TXSC_CLK_SRC = 7;
	localparam int TXSC_NINTH_EN = 6;
	localparam int TXSC_TX_EN = 5;
	localparam int TXSC_SYNC = 4;
	localparam int TXSC_HIGH_SPEED = 2;
	localparam int TXSC_SHIFT_EMPTY = 1;
	localparam int TXSC_NINTH_BIT = 0;
	localparam int RXSC_PORT_EN = 7;
	localparam int RXSC_NINTH_EN = 6;
	localparam int RXSC_SINGLE_EN = 5;
	localparam int RXSC_CONT_EN = 4;
	localparam int RXSC_ADDR_DET = 3;
	localparam int RXSC_FRAME_ERR = 2;
	localparam int RXSC_OVERRUN = 1;
	localparam int RXSC_NINTH_BIT = 0;
	localparam int FLAG_RX_READY = 5;
	localparam int FLAG_TX_EMPTY = 4;
	localparam int GLOBAL_IRQ_EN = 7;
	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_BAUD = 8'h00;
	localparam logic [7:0] RST_TXSC = 8'h02;
	localparam logic [7:0] RST_RXSC = 8'h00;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_FLAG = 8'h00;
	localparam logic [7:0] RST_IRQEN = 8'h00;
	localparam logic [7:0] RST_PRIO = 8'hff;
	// ---------------------------------------------------------------
	// timing counts
	// ---------------------------------------------------------------
	localparam logic [1:0] LOW_SPEED_LAST = 2'h3;
	localparam logic [3:0] OS_LAST = 4'hf;
	localparam logic [3:0] RX_MID = 4'h8;
	localparam logic [3:0] LAST_BIT_8 = 4'h7;
	localparam logic [3:0] LAST_BIT_9 = 4'h8;
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} ast_line_state_type;
endpackage

// ### core/ast_baud_gen.sv
module ast_baud_gen import ast_pkg::*; #(
	parameter int DIV_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [DIV_W-1:0] divisor,
	input wire logic div_wr,
	input wire logic high_speed,
	output logic baud_tick_r,
	output logic os_tick_r
);
	// ---------------------------------------------------------------
	// divisor timer and x64 to x16 prescale
	// ---------------------------------------------------------------
	logic [DIV_W-1:0] tmr_r;
	logic [1:0] pre_r;
	wire tmr_hit = run && (tmr_r == divisor) && !div_wr;
	wire os_hit = tmr_hit && (high_speed || pre_r == LOW_SPEED_LAST);

	// a divisor write restarts the period at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_r <= '0;
			pre_r <= '0;
			baud_tick_r <= 1'b0;
			os_tick_r <= 1'b0;
		end else begin
			if (div_wr || !run || tmr_hit) begin
				tmr_r <= '0;
			end else begin
				tmr_r <= tmr_r + 1'b1;
			end
			if (div_wr || !run) begin
				pre_r <= '0;
			end else if (tmr_hit) begin
				pre_r <= pre_r + 2'h1;
			end
			baud_tick_r <= tmr_hit;
			os_tick_r <= os_hit;
		end
	end

	div_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
		div_wr |=> !baud_tick_r ##1 (!baud_tick_r || divisor == '0))
		else $error("baud timer not restarted by divisor write");
endmodule

// ### core/ast_rx_sampler.sv
module ast_rx_sampler (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic os_tick,
	input wire logic pin,
	output logic vote_r
);
	// ---------------------------------------------------------------
	// three-sample majority filter
	// ---------------------------------------------------------------
	logic [2:0] win_r;
	wire maj = (win_r[0] & win_r[1]) | (win_r[1] & win_r[2]) | (win_r[0] & win_r[2]);

	// window starts at idle level so a reset never looks like a start bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_r <= 3'h7;
			vote_r <= 1'b1;
		end else begin
			if (os_tick) begin
				win_r <= {win_r[1:0], pin};
			end
			vote_r <= maj;
		end
	end
endmodule

// ### tb/ast_remote_node.sv
module ast_remote_node (
	input wire logic pclk,
	input wire logic line_in,
	output logic line_out
);
	timeunit 1ns;
	timeprecision 100ps;
	int bit_cyc = 16;
	int nbits = 8;
	logic [9:0] got_q[$];
	// ------------------------------------------------
	// frame sender, line rests high, driven high from time zero
	// ------------------------------------------------
	initial line_out = 1'b1;
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		line_out <= 1'b0;
		repeat (bit_cyc) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			line_out <= d[i];
			repeat (bit_cyc) @(posedge pclk);
		end
		line_out <= stop;
		repeat (bit_cyc) @(posedge pclk);
		line_out <= 1'b1;
		repeat (bit_cyc) @(posedge pclk);
	endtask
	// ------------------------------------------------
	// frame catcher, stop level kept in bit 9
	// ------------------------------------------------
	// mid-bit sampling tolerates a few cycles of phase slip
	always begin : catch_b
		logic [9:0] v;
		@(negedge line_in);
		v = '0;
		repeat (bit_cyc / 2) @(posedge pclk);
		for (int i = 0; i <= nbits; i++) begin
			repeat (bit_cyc) @(posedge pclk);
			v[(i == nbits) ? 9 : i] = line_in;
		end
		got_q.push_back(v);
	end
endmodule

// ### tb/tb_async_serial_transceiver.sv
module tb_async_serial_transceiver import ast_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic sleep_mode, receive_pin, tx_pin, tx_pin_oe, irq_req, rd_e;
	int n_mismatch = 0;
	int n_compared = 0;
	logic [7:0] ra[9] = '{OFS_BAUD, OFS_TXSC, OFS_RXSC, OFS_TXHOLD, OFS_RXBUF,
		OFS_FLAG, OFS_IRQEN, OFS_PRIO, OFS_GLOBAL};
	logic [7:0] rv[9] = '{RST_BAUD, RST_TXSC, RST_RXSC, RST_DATA, RST_DATA,
		RST_FLAG, RST_IRQEN, RST_PRIO, 8'h00};
	ast_serial_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .sleep_mode, .receive_pin, .tx_pin, .tx_pin_oe,
		.irq_req);
	ast_remote_node rmt_u (.pclk, .line_in(tx_pin), .line_out(receive_pin));
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	// ------------------------------------------------
	// bus and compare helpers
	// ------------------------------------------------
	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// request held until pready is sampled; idle cycle after each
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd_v = prdata;
		rd_e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			n_mismatch++;
			test_done();
		end
		@(posedge pclk);
	endtask
	task automatic w(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic r(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(rd_v, {24'h0, e});
	endtask
	// irq_req is registered, so let two edges land first
	task automatic chk_irq(input logic e);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq_req}, {31'h0, e});
	endtask
	task automatic wait_rx(input logic [9:0] e);
		int n;
		n = 0;
		while (rmt_u.got_q.size() == 0 && n < 4000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 4000) begin
			n_mismatch++;
			test_done();
		end
		chk({22'h0, rmt_u.got_q.pop_front()}, {22'h0, e});
		repeat (rmt_u.bit_cyc) @(posedge pclk);
	endtask
	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin : main_b
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sleep_mode = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 9; i++) r(ra[i], rv[i]);
		apb(1'b0, 8'h24, 8'h00);
		chk(rd_v, 32'h0);
		chk({31'h0, rd_e}, 32'h1);
		w(OFS_PRIO, 8'h5a);
		r(OFS_PRIO, 8'h5a);
		w(OFS_TXSC, 8'h00);
		r(OFS_TXSC, 8'h02);
		$display("test registers done");
		w(OFS_BAUD, 8'h00);
		w(OFS_RXSC, 8'h80);
		// enable register lags the port bit by one edge
		@(posedge pclk);
		chk({31'h0, tx_pin_oe}, 32'h1);
		w(OFS_TXSC, 8'h04);
		r(OFS_FLAG, 8'h00);
		w(OFS_TXSC, 8'h24);
		r(OFS_FLAG, 8'h10);
		w(OFS_FLAG, 8'h00);
		r(OFS_FLAG, 8'h10);
		w(OFS_TXHOLD, 8'ha5);
		r(OFS_TXSC, 8'h24);
		r(OFS_FLAG, 8'h10);
		wait_rx(10'h2a5);
		r(OFS_TXSC, 8'h26);
		w(OFS_TXHOLD, 8'h01);
		w(OFS_TXHOLD, 8'h80);
		r(OFS_FLAG, 8'h00);
		wait_rx(10'h201);
		wait_rx(10'h280);
		w(OFS_TXSC, 8'h65);
		rmt_u.nbits = 9;
		w(OFS_TXHOLD, 8'h3c);
		wait_rx(10'h33c);
		rmt_u.nbits = 8;
		$display("test transmit done");
		w(OFS_TXSC, 8'h20);
		rmt_u.bit_cyc = 64;
		w(OFS_TXHOLD, 8'h96);
		wait_rx(10'h296);
		w(OFS_BAUD, 8'h01);
		w(OFS_TXSC, 8'h24);
		rmt_u.bit_cyc = 32;
		w(OFS_TXHOLD, 8'h69);
		wait_rx(10'h269);
		w(OFS_BAUD, 8'h00);
		rmt_u.bit_cyc = 16;
		sleep_mode <= 1'b1;
		w(OFS_TXHOLD, 8'h77);
		repeat (200) @(posedge pclk);
		chk({31'h0, tx_pin}, 32'h1);
		sleep_mode <= 1'b0;
		wait_rx(10'h277);
		$display("test rate and sleep done");
		w(OFS_RXSC, 8'h90);
		w(OFS_IRQEN, 8'h20);
		rmt_u.send(9'h05a, 8, 1'b1);
		r(OFS_FLAG, 8'h30);
		chk_irq(1'b0);
		w(OFS_GLOBAL, 8'h80);
		chk_irq(1'b1);
		r(OFS_RXSC, 8'h90);
		r(OFS_RXBUF, 8'h5a);
		r(OFS_FLAG, 8'h10);
		chk_irq(1'b0);
		rmt_u.send(9'h033, 8, 1'b0);
		r(OFS_RXSC, 8'h94);
		r(OFS_RXBUF, 8'h33);
		rmt_u.send(9'h011, 8, 1'b1);
		rmt_u.send(9'h022, 8, 1'b1);
		r(OFS_RXSC, 8'h92);
		w(OFS_RXSC, 8'h80);
		r(OFS_RXSC, 8'h80);
		r(OFS_RXBUF, 8'h11);
		$display("test receive done");
		w(OFS_RXSC, 8'hd8);
		rmt_u.send(9'h055, 9, 1'b1);
		r(OFS_FLAG, 8'h10);
		rmt_u.send(9'h1a7, 9, 1'b1);
		r(OFS_RXSC, 8'hd9);
		r(OFS_RXBUF, 8'ha7);
		w(OFS_RXSC, 8'hd0);
		rmt_u.send(9'h0c3, 9, 1'b1);
		r(OFS_RXSC, 8'hd0);
		r(OFS_RXBUF, 8'hc3);
		$display("test address done");
		test_done();
	end
endmodule
